// >>> hdl/rss_pkg.sv
`default_nettype none
package rss_pkg;
   // Opcode fields
   localparam logic [5:0]  ROT_OPC      = 6'h10;   // 0100 00
   localparam logic [6:0]  FILL_OPC     = 7'h34;   // 0110 100
   localparam logic [15:0] SLEEP_WORD   = 16'h0003;
   localparam int          DEST_BIT     = 9;
   localparam int          ACC_BIT      = 8;
   // Addressing, fill value, watchdog and phase constants
   localparam logic [7:0]  IDX_LIMIT    = 8'h5f;
   localparam logic [3:0]  ACCESS_LO    = 4'h0;
   localparam logic [3:0]  ACCESS_HI    = 4'hf;
   localparam logic [7:0]  ALL_ONES     = 8'hff;
   localparam logic [7:0]  WDT_CLEAR    = 8'h00;
   localparam logic [7:0]  WDT_STEP     = 8'h01;
   localparam logic [1:0]  PH_Q1        = 2'h0;
   localparam logic [1:0]  PH_Q4        = 2'h3;
   localparam logic [1:0]  PH_STEP      = 2'h1;
   typedef enum logic [1:0] {
      OP_NONE  = 2'b00,
      OP_ROT   = 2'b01,
      OP_FILL  = 2'b10,
      OP_SLEEP = 2'b11
   } op_t;
endpackage : rss_pkg
`default_nettype wire

// >>> hdl/phase_gen.sv
`default_nettype none
// Four-phase instruction cycle counter; q4 marks the last phase
module phase_gen
   import rss_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   output logic      [1:0] phase,
   output logic            q1,
   output logic            q4
);
   logic [1:0] ph_r;
   logic [1:0] ph_nxt;

   // Free-running phase step
   always_comb begin
      ph_nxt = 2'(ph_r + PH_STEP);
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         ph_r <= PH_Q1;
      end else begin
         ph_r <= ph_nxt;
      end
   end

   assign phase = ph_r;
   assign q1    = (ph_r == PH_Q1);
   assign q4    = (ph_r == PH_Q4);
endmodule : phase_gen
`default_nettype wire

// >>> hdl/rotate_set_sleep_exec.sv
`default_nettype none
// Summary of operation
// - Rotate shifts the byte right, bit 0 into bit 7, and sets only N and Z.
// - Destination bit 0 sends the result to the accumulator, 1 to the file.
// - Rotate: bank bit 0 forces the access bank, 1 uses the bank select.
// - Extended set on, bank bit 0 and address up to 5Fh use indexed offset.
// - Fill writes FFh to the file register and leaves every flag alone.
// - Fill: bank bit 0 targets the access bank, 1 uses the bank select.
// - Sleep clears the power-down flag and sets the time-out flag.
// - Sleep resets the watchdog counter to 00h and clears its postscaler.
// - A watchdog wake-up from sleep clears the time-out flag.
module rotate_set_sleep_exec
   import rss_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr_word,
   input  wire logic        ext_set_en,
   input  wire logic [3:0]  bank_select_reg,
   input  wire logic [7:0]  fsr2_base,
   input  wire logic [7:0]  file_rdata,
   input  wire logic        wdt_wake,
   output logic      [11:0] file_addr,
   output logic             file_rd,
   output logic             file_we,
   output logic      [7:0]  file_wdata,
   output logic             w_we,
   output logic      [7:0]  w_wdata,
   output logic             nz_we,
   output logic             neg_flag,
   output logic             zero_flag,
   output logic             power_down_flag,
   output logic             timeout_flag,
   output logic      [7:0]  watchdog_counter,
   output logic             wdt_post_clr,
   output logic             sleeping,
   output logic      [1:0]  phase_out
);
   logic [1:0] phase;
   logic       q4;

   phase_gen u_phase (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .phase   (phase),
      .q1      (),
      .q4      (q4)
   );

   op_t         op_r,    op_nxt;
   logic        dest_r,  dest_nxt;
   logic [11:0] addr_r,  addr_nxt;
   logic [7:0]  res_r,   res_nxt;
   logic        rd_r,    rd_nxt;
   logic        fwe_r,   fwe_nxt;
   logic [7:0]  fwd_r,   fwd_nxt;
   logic        wwe_r,   wwe_nxt;
   logic [7:0]  wwd_r,   wwd_nxt;
   logic        nzwe_r,  nzwe_nxt;
   logic        neg_r,   neg_nxt;
   logic        zero_r,  zero_nxt;
   logic        pd_r,    pd_nxt;
   logic        to_r,    to_nxt;
   logic [7:0]  wdt_r,   wdt_nxt;
   logic        pclr_r,  pclr_nxt;
   logic        slp_r,   slp_nxt;
   logic [1:0]  ph_r;

   op_t        dec_op;
   logic [7:0] f_lit;
   logic       acc_sel;
   logic [7:0] rot_val;

   // Decode the opcode field and the operand bits
   always_comb begin
      f_lit   = instr_word[7:0];
      acc_sel = instr_word[ACC_BIT];
      dec_op  = OP_NONE;
      if (instr_word == SLEEP_WORD) begin
         dec_op = OP_SLEEP;
      end else if (instr_word[15:10] == ROT_OPC) begin
         dec_op = OP_ROT;
      end else if (instr_word[15:9] == FILL_OPC) begin
         dec_op = OP_FILL;
      end
      rot_val = {file_rdata[0], file_rdata[7:1]};
   end

   // Execution sequencing across Q1..Q4
   always_comb begin
      op_nxt   = op_r;
      dest_nxt = dest_r;
      addr_nxt = addr_r;
      res_nxt  = res_r;
      rd_nxt   = 1'b0;
      fwe_nxt  = 1'b0;
      fwd_nxt  = fwd_r;
      wwe_nxt  = 1'b0;
      wwd_nxt  = wwd_r;
      nzwe_nxt = 1'b0;
      neg_nxt  = neg_r;
      zero_nxt = zero_r;
      pd_nxt   = pd_r;
      to_nxt   = to_r;
      wdt_nxt  = wdt_r;
      pclr_nxt = 1'b0;
      slp_nxt  = slp_r;
      // A sleeping core takes no instruction until woken
      if (slp_r) begin
         // Drop the latched sleep op so it cannot fire again after waking
         op_nxt = OP_NONE;
         if (wdt_wake) begin
            slp_nxt = 1'b0;
            to_nxt  = 1'b0;
         end
      end else begin
         // Counter advances once per instruction cycle while awake
         if (q4) begin
            wdt_nxt = 8'(wdt_r + WDT_STEP);
         end
         case (phase)
            2'h0: begin
               // Q1 decode; the op is latched only from a valid word, dest and address from any word
               op_nxt   = instr_valid ? dec_op : OP_NONE;
               dest_nxt = instr_word[DEST_BIT];
               if (!acc_sel && ext_set_en && f_lit <= IDX_LIMIT) begin
                  addr_nxt = {ACCESS_LO, 8'(fsr2_base + f_lit)};
               end else if (!acc_sel) begin
                  // Access bank: low half to bank 0, upper to SFRs
                  addr_nxt = {f_lit[7] ? ACCESS_HI : ACCESS_LO,
                              f_lit};
               end else begin
                  addr_nxt = {bank_select_reg, f_lit};
               end
               rd_nxt = instr_valid && (dec_op == OP_ROT);
            end
            2'h1: begin
               // Q2 read data are taken here
               if (op_r == OP_ROT) begin
                  res_nxt = rot_val;
               end
            end
            2'h2: begin
               // Q3 process; results stage for the Q4 strobe
               case (op_r)
                  OP_ROT: begin
                     if (dest_r) begin
                        fwe_nxt = 1'b1;
                        fwd_nxt = res_r;
                     end else begin
                        wwe_nxt = 1'b1;
                        wwd_nxt = res_r;
                     end
                     nzwe_nxt = 1'b1;
                     neg_nxt  = res_r[7];
                     zero_nxt = (res_r == WDT_CLEAR);
                  end
                  OP_FILL: begin
                     fwe_nxt = 1'b1;
                     fwd_nxt = ALL_ONES;
                  end
                  OP_SLEEP: begin
                     pd_nxt   = 1'b0;
                     to_nxt   = 1'b1;
                     wdt_nxt  = WDT_CLEAR;
                     pclr_nxt = 1'b1;
                     slp_nxt  = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
            default: begin
               op_nxt = OP_NONE;
            end
         endcase
      end
   end

   // Register everything; reset puts flags at their power-on levels
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         op_r   <= OP_NONE;
         dest_r <= 1'b0;
         addr_r <= '0;
         res_r  <= '0;
         rd_r   <= 1'b0;
         fwe_r  <= 1'b0;
         fwd_r  <= '0;
         wwe_r  <= 1'b0;
         wwd_r  <= '0;
         nzwe_r <= 1'b0;
         neg_r  <= 1'b0;
         zero_r <= 1'b0;
         pd_r   <= 1'b1;
         to_r   <= 1'b1;
         wdt_r  <= WDT_CLEAR;
         pclr_r <= 1'b0;
         slp_r  <= 1'b0;
         ph_r   <= PH_Q1;
      end else begin
         op_r   <= op_nxt;
         dest_r <= dest_nxt;
         addr_r <= addr_nxt;
         res_r  <= res_nxt;
         rd_r   <= rd_nxt;
         fwe_r  <= fwe_nxt;
         fwd_r  <= fwd_nxt;
         wwe_r  <= wwe_nxt;
         wwd_r  <= wwd_nxt;
         nzwe_r <= nzwe_nxt;
         neg_r  <= neg_nxt;
         zero_r <= zero_nxt;
         pd_r   <= pd_nxt;
         to_r   <= to_nxt;
         wdt_r  <= wdt_nxt;
         pclr_r <= pclr_nxt;
         slp_r  <= slp_nxt;
         ph_r   <= phase;
      end
   end

   assign file_addr        = addr_r;
   assign file_rd          = rd_r;
   assign file_we          = fwe_r;
   assign file_wdata       = fwd_r;
   assign w_we             = wwe_r;
   assign w_wdata          = wwd_r;
   assign nz_we            = nzwe_r;
   assign neg_flag         = neg_r;
   assign zero_flag        = zero_r;
   assign power_down_flag  = pd_r;
   assign timeout_flag     = to_r;
   assign watchdog_counter = wdt_r;
   assign wdt_post_clr     = pclr_r;
   assign sleeping         = slp_r;
   assign phase_out        = ph_r;
endmodule : rotate_set_sleep_exec
`default_nettype wire

// >>> bench/rss_properties.sv
`default_nettype none
// Port-level checks of the rotate, fill and sleep executor
module rss_checker
   import rss_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       rst_b,
   input wire logic [7:0] file_rdata,
   input wire logic       wdt_wake,
   input wire logic       file_rd,
   input wire logic       file_we,
   input wire logic [7:0] file_wdata,
   input wire logic       w_we,
   input wire logic [7:0] w_wdata,
   input wire logic       nz_we,
   input wire logic       neg_flag,
   input wire logic       zero_flag,
   input wire logic       power_down_flag,
   input wire logic       timeout_flag,
   input wire logic [7:0] watchdog_counter,
   input wire logic       wdt_post_clr,
   input wire logic       sleeping
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   // Rotate result from whichever destination took it
   wire logic [7:0] res = file_we ? file_wdata : w_wdata;
   // Bench holds file_rdata for the whole instruction, so it is the operand
   a_rd_pulse: assert property (file_rd |=> !file_rd)
      else $error("read strobe held");
   a_rd_to_write: assert property (file_rd |-> ##[2:3] nz_we)
      else $error("rotate never wrote");
   a_one_dest: assert property (nz_we |-> file_we ^ w_we)
      else $error("rotate destination wrong");
   a_rot_value: assert property (nz_we |->
      res == {file_rdata[0], file_rdata[7:1]} && neg_flag == res[7]
      && zero_flag == (res == 8'h00))
      else $error("rotate value or flags wrong");
   a_fill_value: assert property (file_we && !nz_we |->
      file_wdata == ALL_ONES && $stable({neg_flag, zero_flag}))
      else $error("fill value or flags wrong");
   a_sleep_entry: assert property ($rose(sleeping) |->
      !power_down_flag && timeout_flag && wdt_post_clr
      && watchdog_counter == WDT_CLEAR)
      else $error("sleep entry wrong");
   a_wake_clear: assert property (sleeping && wdt_wake |=>
      !sleeping && !timeout_flag)
      else $error("wake wrong");
   a_asleep_quiet: assert property (sleeping && $past(sleeping) |->
      !file_we && !w_we && !file_rd)
      else $error("access while asleep");
   c_rot_w: cover property (nz_we && w_we);
   c_fill: cover property (file_we && !nz_we);
   c_wake: cover property (sleeping && wdt_wake);
endmodule : rss_checker
bind rotate_set_sleep_exec rss_checker chk_inst (.sys_clk(sys_clk),
   .rst_b(rst_b), .file_rdata(file_rdata), .wdt_wake(wdt_wake),
   .file_rd(file_rd), .file_we(file_we), .file_wdata(file_wdata),
   .w_we(w_we), .w_wdata(w_wdata), .nz_we(nz_we), .neg_flag(neg_flag),
   .zero_flag(zero_flag), .power_down_flag(power_down_flag),
   .timeout_flag(timeout_flag), .watchdog_counter(watchdog_counter),
   .wdt_post_clr(wdt_post_clr), .sleeping(sleeping));
`default_nettype wire

// >>> bench/tb_rotate_set_sleep_exec.sv
`default_nettype none
`define CK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; \
   $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_rotate_set_sleep_exec
   import rss_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, rst_b, instr_valid, ext_set_en, wdt_wake;
   logic [15:0] instr_word;
   logic [3:0]  bank_select_reg;
   logic [7:0]  fsr2_base, file_rdata, file_wdata, w_wdata, watchdog_counter;
   logic [11:0] file_addr, addr_c;
   logic        file_rd, file_we, w_we, nz_we, neg_flag, zero_flag;
   logic        power_down_flag, timeout_flag, wdt_post_clr, sleeping;
   logic [1:0]  phase_out, n_rd, n_we, n_w, n_nz, n_pc, ph_c;
   logic [7:0]  d_c;
   int          mismatches, check_count;
   rotate_set_sleep_exec rotate_set_sleep_exec_inst (.sys_clk(sys_clk),
      .rst_b(rst_b), .instr_valid(instr_valid), .instr_word(instr_word),
      .ext_set_en(ext_set_en), .bank_select_reg(bank_select_reg),
      .fsr2_base(fsr2_base), .file_rdata(file_rdata), .wdt_wake(wdt_wake),
      .file_addr(file_addr), .file_rd(file_rd), .file_we(file_we),
      .file_wdata(file_wdata), .w_we(w_we), .w_wdata(w_wdata),
      .nz_we(nz_we), .neg_flag(neg_flag), .zero_flag(zero_flag),
      .power_down_flag(power_down_flag), .timeout_flag(timeout_flag),
      .watchdog_counter(watchdog_counter), .wdt_post_clr(wdt_post_clr),
      .sleeping(sleeping), .phase_out(phase_out));
   // 8 ns clock
   always #4 sys_clk = ~sys_clk;
   task automatic close_out();
      $display("mismatches %0d check_count %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out
   // One instruction in eight cycles, so every take lands on Q1
   task automatic run(input logic [15:0] w, input logic [7:0] rd,
                      input logic ex, input logic [3:0] bs);
      instr_valid <= 1'b1; instr_word <= w; file_rdata <= rd;
      ext_set_en <= ex; bank_select_reg <= bs;
      {n_rd, n_we, n_w, n_nz, n_pc} = '0;
      @(posedge sys_clk); instr_valid <= 1'b0;
      // Look 1 ns after each edge from the take edge on: the read pulse
      // stands only in the cycle right after the take
      for (int k = 0; k < 6; k++) begin
         #1;
         if (k == 0) begin addr_c = file_addr; ph_c = phase_out; end
         if (file_rd === 1'b1) n_rd++;
         if (file_we === 1'b1) begin n_we++; d_c = file_wdata; end
         if (w_we === 1'b1) begin n_w++; d_c = w_wdata; end
         if (nz_we === 1'b1) n_nz++;
         if (wdt_post_clr === 1'b1) n_pc++;
         @(posedge sys_clk);
      end
      @(posedge sys_clk);
   endtask : run
   // Expect {read, file write, acc write, flag write, neg, zero}
   task automatic t(input logic [15:0] w, input logic [7:0] rd, input logic ex,
                    input logic [3:0] bs, input logic [11:0] ea,
                    input logic [7:0] ed, input logic [5:0] ek);
      run(w, rd, ex, bs);
      `CK({n_rd == 2'd1, n_we == 2'd1, n_w == 2'd1, n_nz == 2'd1,
           neg_flag, zero_flag}, ek)
      `CK(ph_c, PH_Q1)
      if (|ek[5:3]) `CK(addr_c, ea)
      if (|ek[4:3]) `CK(d_c, ed)
   endtask : t
   // Cut a hang short
   initial begin #20000; mismatches++; close_out(); end
   initial begin
      sys_clk = 0; rst_b = 0; instr_valid = 0; instr_word = '0; wdt_wake = 0;
      ext_set_en = 0; bank_select_reg = '0; fsr2_base = 8'h10; file_rdata = '0;
      repeat (4) @(posedge sys_clk); #1;
      `CK({power_down_flag, timeout_flag, sleeping, watchdog_counter},
          11'h600)
      @(posedge sys_clk); rst_b <= 1'b1;
      t(16'h4345, 8'hd7, 0, 4'h3, 12'h345, 8'heb, 6'b110110);
      t(16'h4090, 8'h01, 0, 4'h3, 12'hf90, 8'h80, 6'b101110);
      t(16'h4220, 8'h00, 0, 4'h3, 12'h020, 8'h00, 6'b110101);
      t(16'h425f, 8'h02, 1, 4'h3, 12'h06f, 8'h01, 6'b110100);
      t(16'h4260, 8'h03, 1, 4'h3, 12'h060, 8'h81, 6'b110110);
      t(16'h4310, 8'h01, 1, 4'h5, 12'h510, 8'h80, 6'b110110);
      t(16'h6933, 8'h00, 1, 4'h2, 12'h233, 8'hff, 6'b010010);
      t(16'h68a0, 8'h00, 0, 4'h2, 12'hfa0, 8'hff, 6'b010010);
      t(16'h4400, 8'h55, 0, 4'h2, 12'h000, 8'h00, 6'b000010);
      // The counter has run by now, so the clear below is visible
      `CK(watchdog_counter != WDT_CLEAR, 1'b1)
      run(SLEEP_WORD, 8'h00, 0, 4'h0);
      `CK({power_down_flag, timeout_flag, sleeping, n_pc, watchdog_counter},
          13'h0d00)
      run(16'h6933, 8'h00, 0, 4'h2);
      `CK({n_rd, n_we, n_w}, 6'h00)
      wdt_wake <= 1'b1;
      repeat (2) @(posedge sys_clk);
      wdt_wake <= 1'b0; #1;
      `CK({sleeping, timeout_flag}, 2'b00)
      repeat (2) @(posedge sys_clk);
      t(16'h4345, 8'h00, 0, 4'h3, 12'h345, 8'h00, 6'b110101);
      run(SLEEP_WORD, 8'h00, 0, 4'h0);
      `CK(timeout_flag, 1'b1)
      close_out();
   end
endmodule : tb_rotate_set_sleep_exec
`default_nettype wire
